//--- crs_top.sv
// Chip reset sequencer: merges reset sources, times the wake-up and
// runs the external interrupt inputs that can wake from power-down.
// Assumes all inputs are synchronous to clk_sys; reset is synchronous.
//
// How it works
// - Any of four reset sources asserts chip reset.
// - Reset with usable supply drives indicator low, starts wake timer.
// - Hold reset until pin released, oscillator runs, count done, flash ready.
// - Indicator goes high the cycle after release; after brownout, once supply recovers.
// - Fetch begins at address zero, the boot reset vector.
// - Edge interrupt slices hold reset values until internal reset drops.
// - Up to thirty edge inputs and one level input, each on its own port.
// - External interrupt can wake processor from power-down when enabled.
// - Run from RC oscillator at 4 MHz after power-up and wake.
// - Wake timer monitors crystal and reports when it is stable.
`timescale 1ns/1ps
module crs_top
    import crs_pkg::*;
#(
    parameter int NUM_EDGE_IRQ = 30,
    parameter int WAKE_COUNT = WAKE_COUNT_DEF
)
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Reset sources.
    input wire logic reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic power_on_detect,
    input wire logic brownout_detect,
    input wire logic supply_usable,
    // Oscillator and flash status.
    input wire logic xtal_running,
    input wire logic flash_init_done,
    // Software controls.
    input wire logic [1:0] clk_src_sel,
    input wire logic [31:0] vtab_offset,
    input wire logic [NUM_EDGE_IRQ-1:0] edge_irq_pin,
    input wire logic [NUM_EDGE_IRQ-1:0] edge_irq_enable,
    input wire logic [NUM_EDGE_IRQ-1:0] edge_irq_clear,
    input wire logic level_irq_pin,
    input wire logic level_irq_enable,
    input wire logic wake_enable,
    input wire logic power_down,
    // Outputs.
    output logic chip_reset,
    output logic internal_reset,
    output logic reset_indicator_out,
    output logic xtal_stable,
    output logic rc_clk_en,
    output logic clk_from_rc,
    output logic [31:0] fetch_addr,
    output logic fetch_start,
    output logic vtab_ok,
    output logic [NUM_EDGE_IRQ-1:0] edge_irq_pending,
    output logic level_irq_active,
    output logic wake_request,
    output logic power_down_active
);
    // Refuses parameter values that the logic cannot serve.
    if (NUM_EDGE_IRQ < 1 || NUM_EDGE_IRQ > 30)
    begin : g_bad_irq_count
        $error("NUM_EDGE_IRQ must be 1 to 30");
    end
    if (WAKE_COUNT < 1)
    begin : g_bad_wake_count
        $error("WAKE_COUNT must be at least 1");
    end

    localparam int CW = $clog2(WAKE_COUNT + 1);
    localparam int DW = $clog2(RC_DIV_CYCLES + 1);
    localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_COUNT - 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(RC_DIV_CYCLES - 1);

    crs_state_t state_q;
    crs_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [DW-1:0] div_q;
    logic [DW-1:0] div_d;
    logic reset_indicator_out_q;
    logic reset_indicator_out_d;
    logic bod_seen_q;
    logic bod_seen_d;
    logic pd_q;
    logic pd_d;
    logic wake_rc_q;
    logic wake_rc_d;
    logic fetch_q;
    logic fetch_d;
    logic src_any;
    logic rc_tick;
    logic any_irq;

    assign src_any = !reset_pin_n || watchdog_timeout || power_on_detect ||
                     brownout_detect;
    assign chip_reset = src_any || reset;

    assign rc_tick = (div_q == DIV_LAST);
    always_comb
    begin
        div_d = rc_tick ? '0 : DW'(div_q + 1'b1);
    end

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        fetch_d = 1'b0;
        if (src_any && supply_usable)
        begin
            state_d = CRS_HOLD;
            cnt_d = '0;
        end
        else
        begin
            case (state_q)
                CRS_HOLD:
                    if (reset_pin_n)
                        state_d = CRS_OSC;
                CRS_OSC:
                    if (xtal_running)
                    begin
                        state_d = CRS_COUNT;
                        cnt_d = '0;
                    end
                CRS_COUNT:
                    if (!xtal_running)
                        state_d = CRS_OSC;
                    else if (rc_tick)
                    begin
                        if (cnt_q == WAKE_LAST)
                            state_d = CRS_FLASH;
                        else
                            cnt_d = CW'(cnt_q + 1'b1);
                    end
                CRS_FLASH:
                    if (flash_init_done)
                    begin
                        state_d = CRS_RUN;
                        fetch_d = 1'b1;
                    end
                CRS_RUN:
                    state_d = CRS_RUN;
                default:
                    state_d = CRS_HOLD;
            endcase
        end
    end

    always_comb
    begin
        bod_seen_d = bod_seen_q || brownout_detect;
        reset_indicator_out_d = reset_indicator_out_q;
        if (src_any && supply_usable)
            reset_indicator_out_d = 1'b0;
        else if (state_q == CRS_RUN && !(bod_seen_q && brownout_detect))
        begin
            reset_indicator_out_d = 1'b1;
            bod_seen_d = brownout_detect;
        end
    end

    always_comb
    begin
        pd_d = pd_q;
        // RC after wake.
        // Software leaves RC after a wake by selecting RC, then its source.
        wake_rc_d = pd_q || (wake_rc_q && clk_src_sel != CLK_SEL_RC);
        if (pd_q && wake_enable && any_irq)
            pd_d = 1'b0;
        else if (power_down && state_q == CRS_RUN)
            pd_d = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset || (src_any && supply_usable))
        begin
            state_q <= CRS_HOLD;
            cnt_q <= '0;
            div_q <= '0;
            reset_indicator_out_q <= 1'b0;
            bod_seen_q <= 1'b0;
            pd_q <= 1'b0;
            wake_rc_q <= 1'b0;
            fetch_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            reset_indicator_out_q <= reset_indicator_out_d;
            bod_seen_q <= bod_seen_d;
            pd_q <= pd_d;
            wake_rc_q <= wake_rc_d;
            fetch_q <= fetch_d;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EDGE_IRQ; gi++)
        begin : g_edge
            crs_edge_irq u_edge (
                .clk_sys(clk_sys),
                .reset(internal_reset),
                .pin_in(edge_irq_pin[gi]),
                .enable(edge_irq_enable[gi]),
                .clear(edge_irq_clear[gi]),
                .pending(edge_irq_pending[gi])
            );
        end
    endgenerate

    assign level_irq_active = level_irq_pin && level_irq_enable;
    assign any_irq = level_irq_active || (|edge_irq_pending);

    assign internal_reset = (state_q != CRS_RUN) || src_any || reset;
    assign reset_indicator_out = reset_indicator_out_q;
    assign xtal_stable = (state_q == CRS_FLASH) || (state_q == CRS_RUN);
    // RC clock until switched, and after wake.
    assign clk_from_rc = internal_reset || pd_q || wake_rc_q ||
                         (clk_src_sel == CLK_SEL_RC);
    assign rc_clk_en = rc_tick;
    assign fetch_addr = RESET_VECTOR_ADDR;
    assign fetch_start = fetch_q;
    assign vtab_ok = (vtab_offset < VTAB_LIMIT) &&
                     (vtab_offset[VTAB_ALIGN_BITS-1:0] == '0);
    assign wake_request = pd_q && wake_enable && any_irq;
    assign power_down_active = pd_q;
endmodule : crs_top

//--- crs_pkg.sv
// Constants shared by the chip reset sequencer and its interrupt slice.
// Assumes a single 250 MHz system clock and a synchronous reset.
package crs_pkg;
    // System clock rate.
    localparam int CLK_SYS_MHZ = 250;
    // Internal RC oscillator rate while no other source is chosen.
    localparam int RC_OSC_MHZ = 4;
    // Divider count from the system clock down to the RC rate.
    localparam int RC_DIV_CYCLES = CLK_SYS_MHZ / RC_OSC_MHZ;
    // Default wake-up count in oscillator clocks.
    localparam int WAKE_COUNT_DEF = 1024;
    // Address where fetching starts after reset.
    localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0000;
    // Vector table placement limits.
    localparam logic [31:0] VTAB_LIMIT = 32'h4000_0000;
    localparam int VTAB_ALIGN_BITS = 9;
    // Clock source selector codes.
    localparam logic [1:0] CLK_SEL_RC = 2'h0;
    localparam logic [1:0] CLK_SEL_XTAL = 2'h1;
    localparam logic [1:0] CLK_SEL_PLL = 2'h2;
    // Sequencer states.
    typedef enum logic [2:0] {
        CRS_HOLD = 3'b000,
        CRS_OSC = 3'b001,
        CRS_COUNT = 3'b010,
        CRS_FLASH = 3'b011,
        CRS_RUN = 3'b100
    } crs_state_t;
endpackage : crs_pkg

//--- crs_edge_irq.sv
// One edge-sensitive external interrupt input with a pending flag.
// Assumes the pin is already synchronous to clk_sys.
`timescale 1ns/1ps
module crs_edge_irq
    import crs_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Pin and control.
    input wire logic pin_in,
    input wire logic enable,
    input wire logic clear,
    // Result.
    output logic pending
);
    logic prev_q;
    logic prev_d;
    logic pend_q;
    logic pend_d;

    // Rising edge sets the flag; an edge beats a clear in the same cycle.
    always_comb
    begin
        prev_d = pin_in;
        pend_d = pend_q;
        if (clear)
        begin
            pend_d = 1'b0;
        end
        if (enable && pin_in && !prev_q)
        begin
            pend_d = 1'b1;
        end
    end

    // Registers the edge state.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prev_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
            pend_q <= pend_d;
        end
    end

    assign pending = pend_q;
endmodule : crs_edge_irq

//--- crs_top_asserts.sv
// Port checker for the chip reset sequencer.
// Assumes it is bound to crs_top with every signal on clk_sys.
`timescale 1ns/1ps
module crs_top_asserts
    import crs_pkg::*;
#(
    parameter int NUM_EDGE_IRQ = 30
)
(
    // Clock, reset and sources.
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic power_on_detect,
    input wire logic brownout_detect,
    input wire logic supply_usable,
    input wire logic xtal_running,
    input wire logic flash_init_done,
    // Controls.
    input wire logic [31:0] vtab_offset,
    input wire logic [NUM_EDGE_IRQ-1:0] edge_irq_pin,
    input wire logic [NUM_EDGE_IRQ-1:0] edge_irq_enable,
    // Outputs.
    input wire logic chip_reset,
    input wire logic internal_reset,
    input wire logic reset_indicator_out,
    input wire logic xtal_stable,
    input wire logic rc_clk_en,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_start,
    input wire logic vtab_ok,
    input wire logic [NUM_EDGE_IRQ-1:0] edge_irq_pending
);
    // Every check runs on the system clock and rests in reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic any_src;
    // Any one of the four sources.
    assign any_src = !reset_pin_n || watchdog_timeout ||
        power_on_detect || brownout_detect;
    sequence s_release;
        $fell(internal_reset);
    endsequence
    property p_src; any_src |-> chip_reset && internal_reset; endproperty
    property p_low; any_src && supply_usable |=> !reset_indicator_out;
    endproperty
    property p_hold;
        s_release |-> reset_pin_n && xtal_running && flash_init_done;
    endproperty
    property p_high; s_release |-> ##[1:2] reset_indicator_out; endproperty
    property p_fetch;
        s_release |-> ##[0:1] fetch_start && fetch_addr == RESET_VECTOR_ADDR;
    endproperty
    property p_vtab;
        vtab_ok == (vtab_offset < VTAB_LIMIT && vtab_offset[8:0] == 9'h000);
    endproperty
    // A source restarts the divider, so spacing is not held across it.
    property p_rc;
        disable iff (chip_reset) rc_clk_en |=> !rc_clk_en ##61 rc_clk_en;
    endproperty
    property p_xtal; $rose(xtal_stable) |-> $past(xtal_running); endproperty
    property p_edge;
        $rose(edge_irq_pin[0]) && edge_irq_enable[0] && !internal_reset
        |=> edge_irq_pending[0];
    endproperty
    a_src: assert property (p_src) else $error("source missed");
    a_low: assert property (p_low) else $error("indicator high");
    a_hold: assert property (p_hold) else $error("early release");
    a_high: assert property (p_high) else $error("indicator low");
    a_fetch: assert property (p_fetch) else $error("no fetch");
    a_vtab: assert property (p_vtab) else $error("table check");
    a_rc: assert property (p_rc) else $error("rc tick spacing");
    a_xtal: assert property (p_xtal) else $error("xtal stable");
    a_edge: assert property (p_edge) else $error("edge lost");
endmodule : crs_top_asserts
bind crs_top crs_top_asserts #(.NUM_EDGE_IRQ(NUM_EDGE_IRQ)) u_chk (.*);

//--- crs_board_model.sv
// Board model: reset button, crystal and flash status.
// Assumes press comes from the bench on clk_sys edges.
`timescale 1ns/1ps
module crs_board_model
(
    // Clock and controls.
    input wire logic clk_sys,
    input wire logic press,
    input wire logic slow,
    // Board status.
    output logic reset_pin_n,
    output logic xtal_running,
    output logic flash_init_done
);
    logic [7:0] cnt_q;
    // Cycles since the last press, held at the top.
    always_ff @(posedge clk_sys)
        cnt_q <= press ? 8'h00 : cnt_q + 8'(cnt_q != 8'hFF);
    // Pin held low.
    // A slow board brings each line up late.
    assign reset_pin_n = cnt_q > (slow ? 8'h20 : 8'h03);
    assign xtal_running = cnt_q > (slow ? 8'h40 : 8'h06);
    assign flash_init_done = cnt_q > (slow ? 8'h80 : 8'h09);
endmodule : crs_board_model

//--- test_chip_reset_sequencer.sv
// Self-checking bench for crs_top with a board model.
// Assumes a 4 ns clk_sys and a short wake count.
`timescale 1ns/1ps
module test_chip_reset_sequencer
    import crs_pkg::*;
;
    logic clk_sys = 1'b0, reset = 1'b1, press = 1'b1, slow = 1'b0;
    logic watchdog_timeout = 1'b0, power_on_detect = 1'b0;
    logic brownout_detect = 1'b0, supply_usable = 1'b1, go = 1'b0;
    logic level_irq_pin, level_irq_enable, wake_enable, power_down;
    logic [1:0] clk_src_sel;
    logic [31:0] vtab_offset = 32'h0, fetch_addr, v, e;
    logic pd_ref = 1'b0, rcw_ref = 1'b0, lvl_exp, irq_now, rc_exp;
    logic [29:0] edge_irq_pin = 30'h0, edge_irq_enable = 30'h0;
    logic [29:0] edge_irq_clear = 30'h0, edge_irq_pending;
    logic reset_pin_n, xtal_running, flash_init_done, chip_reset;
    logic internal_reset, reset_indicator_out, xtal_stable, rc_clk_en;
    logic clk_from_rc, fetch_start, vtab_ok, level_irq_active;
    logic wake_request, power_down_active;
    logic [31:0] exp_q[$];
    logic [31:0] tab[4] = '{32'h3FFFFE00, 32'h40000000, 32'h200, 32'h100};
    int n_errors = 0, n_compared = 0, k, b;
    crs_top #(.WAKE_COUNT(2)) uut (.*);
    crs_board_model u_board (.clk_sys(clk_sys), .press(press),
        .slow(slow), .reset_pin_n(reset_pin_n),
        .xtal_running(xtal_running), .flash_init_done(flash_init_done));
    // Clock and random software controls.
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        {clk_src_sel, level_irq_pin, level_irq_enable, wake_enable,
            power_down} <= go ? 6'($urandom) : 6'h00;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task test_done;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // Waits for the boot fetch, then checks the released state.
    task boot;
        int i;
        exp_q.push_back(RESET_VECTOR_ADDR);
        for (i = 0; i < 600 && fetch_start !== 1'b1; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        chk(i < 600, 1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({internal_reset, reset_indicator_out}, 2'b01);
    endtask : boot
    // Each boot fetch is matched against the oldest note.
    always @(posedge clk_sys)
        if (fetch_start === 1'b1)
        begin
            e = exp_q.size() ? exp_q.pop_front() : 32'hF;
            chk(fetch_addr, e);
        end
    // Power-down and clock-source model, fed the values seen at each edge.
    assign lvl_exp = level_irq_pin && level_irq_enable;
    assign irq_now = lvl_exp || (|edge_irq_pending);
    assign rc_exp = internal_reset || pd_ref || rcw_ref ||
        clk_src_sel == CLK_SEL_RC;
    always @(posedge clk_sys)
        if (reset || (supply_usable && (!reset_pin_n || watchdog_timeout ||
            power_on_detect || brownout_detect)))
        begin
            pd_ref <= 1'b0;
            rcw_ref <= 1'b0;
        end
        else
        begin
            pd_ref <= pd_ref ? !(wake_enable && irq_now) :
                power_down && !internal_reset;
            rcw_ref <= pd_ref || (rcw_ref && clk_src_sel != CLK_SEL_RC);
        end
    // Level, wake and clock-source outputs, checked mid-cycle.
    always @(negedge clk_sys)
        if (!reset)
        begin
            chk(level_irq_active, lvl_exp);
            chk(power_down_active, pd_ref);
            chk(wake_request, pd_ref && wake_enable && irq_now);
            chk(clk_from_rc, rc_exp);
        end
    initial
    begin
        #40000;
        n_errors++;
        test_done();
    end
    initial
    begin
        void'($urandom(32'hEF249EBB));
        go = 1'b1;
        repeat (10) @(posedge clk_sys);
        {reset, press, slow} <= 3'b001;
        boot();
        // One pass for each source, the pin last.
        for (k = 0; k < 4; k++)
        begin
            @(posedge clk_sys);
            slow <= k[0];
            press <= k == 3;
            {brownout_detect, power_on_detect, watchdog_timeout} <=
                3'(k < 3 ? 1 << k : 0);
            @(posedge clk_sys);
            #1;
            chk(chip_reset, 1'b1);
            @(posedge clk_sys);
            {brownout_detect, power_on_detect, watchdog_timeout} <= 3'h0;
            press <= 1'b0;
            #1;
            chk({reset_indicator_out, internal_reset}, 2'b01);
            boot();
        end
        // Edge inputs, one disabled pass, one clear in the edge cycle.
        for (k = 0; k < 8; k++)
        begin
            b = k ? $urandom_range(29) : 0;
            @(posedge clk_sys);
            edge_irq_enable <= k == 1 ? 30'h0 : 30'h3FFFFFFF;
            {edge_irq_clear, edge_irq_pin} <= {30'h3FFFFFFF, 30'h0};
            @(posedge clk_sys);
            edge_irq_pin <= 30'h1 << b;
            // A clear in the edge cycle loses to the edge.
            edge_irq_clear <= k == 2 ? 30'h3FFFFFFF : 30'h0;
            @(posedge clk_sys);
            #1;
            chk(edge_irq_pending, k == 1 ? 0 : 32'h1 << b);
        end
        for (k = 0; k < 12; k++)
        begin
            v = $urandom & (k[0] ? 32'h7FFFFE00 : 32'hFFFFFFFF);
            if (k < 4)
                v = tab[k];
            @(posedge clk_sys);
            vtab_offset <= v;
            @(posedge clk_sys);
            #1;
            chk(vtab_ok, v < 32'h40000000 && v[8:0] == 9'h000);
        end
        test_done();
    end
endmodule : test_chip_reset_sequencer
